// ### tb/e1_irq_ccs_ctl_tb.sv
`timescale 1ns/100ps
module e1_irq_ccs_ctl_tb;
  // group bit of each event, index = mask word * 8 + bit; -1 has no plain event input
  localparam int GRP [32] = '{2, 4, 5, 6, 6, 6, 6, 7, 0, 5, -1, -1, 5, 5, 5, 5,
    4, 6, 4, 2, 4, 3, 4, 4, -1, 3, 3, 3, 7, -1, 7, 7};
  localparam int CHG = 21;
  localparam int SLOT = 1920;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic busCsN = 1'b1, busRdN = 1'b1, busWrN = 1'b1;
  logic [4:0] busAddr = 5'h00;
  logic [7:0] busDataIn = 8'h00;
  logic c4 = 1'b0, lc = 1'b0;
  logic [8:0] cnt = 9'h000;
  logic [7:0] lcnt = 8'h00;
  int c4Div = 0, lcDiv = 0;
  logic ccsIn = 1'b0, msnTb = 1'b1, rxBit = 1'b1;
  logic [3:0] tbNib = 4'h6, rxNib = 4'h9;
  logic aOne = 1'b0, eZero = 1'b0, ack = 1'b0, susp = 1'b0;
  logic [1:0] hs = 2'h0, he = 2'h0;
  logic [31:0] ev = 32'h00000000;
  logic [7:0] busDataOut, irqVector;
  logic busDataOe, sigOut, sigOe, rxClk, rxClkOe, txBit, txStb, abcdStb, clrOut, irqN, irqOe;
  logic [3:0] txNib;
  wire logic sigIn;
  int failures = 0;
  int comparisons = 0;
  // tb drives the valid half of each slot only, so a wrong half gives a wrong nibble
  assign sigIn = ccsIn | ((cnt[3] ^ msnTb) & tbNib[~cnt[2:1]]);

  e1_irq_ccs_ctl #(.RAI_MIN_CYCLES(27'h000000A), .RAI_MAX_CYCLES(27'h0000032)) dut (
    .ref_clk, .rst, .busCsN, .busRdN, .busWrN, .busAddr, .busDataIn, .busDataOut, .busDataOe,
    .backplane4mhzClockIn(c4), .backplaneFrameN(cnt != 9'h000), .signallingSerialIn(sigIn),
    .signallingSerialOut(sigOut), .signallingSerialOe(sigOe), .lineClockIn(lc),
    .lineFrameIn(lcnt == 8'h00), .rxCcsClockOut(rxClk), .rxCcsClockOe(rxClkOe),
    .rxCcsBit(rxBit), .rxAbcdNibble(rxNib), .txCcsBit(txBit), .txCcsStrobe(txStb),
    .txAbcdNibble(txNib), .txAbcdStrobe(abcdStb), .statusCounterClear(clrOut),
    .frameSyncLoss(ev[7]), .remoteAlarm(ev[6]), .allOnesAlarm(ev[5]), .ts16AllOnes(ev[4]),
    .signalLoss(ev[3]), .frameErrorEvt(ev[2]), .bpvCounterWrap(ev[1]), .slipEvt(ev[0]),
    .remoteCrcErrorEvt(ev[15]), .localCrcErrorEvt(ev[14]), .doubleFasErrorEvt(ev[13]),
    .bipolarViolationEvt(ev[12]), .rxAbitOne(aOne), .rxEbitsZero(eZero),
    .testBitErrorEvt(ev[9]), .abcdChangeEvt(ev[8]), .ebitCounterWrap(ev[23]),
    .crcCounterWrap(ev[22]), .crcAlignStatus(ev[21]), .fasCounterWrap(ev[20]),
    .jitterFifoNearLimit(ev[19]), .testErrorCounterWrap(ev[18]), .auxPatternStatus(ev[17]),
    .crcMultiframeWrap(ev[16]), .sigMultiframeLoss(ev[31]), .crcMultiframeLoss(ev[30]),
    .remoteMultiframeAlarm(ev[28]), .oneSecondStatus(ev[27]), .firstTimerStatus(ev[26]),
    .secondTimerStatus(ev[25]), .hdlc0Select(hs[0]), .hdlc1Select(hs[1]), .hdlc0Evt(he[0]),
    .hdlc1Evt(he[1]), .irqAckToggle(ack), .irqSuspend(susp), .irqN, .irqOe, .irqVector);

  initial forever #4 ref_clk = ~ref_clk;

  // 30 ref cycles per 4 MHz backplane clock period (60 per backplane bit), 60 per line bit
  always @(negedge ref_clk)
  begin
    c4Div <= (c4Div == 14) ? 0 : c4Div + 1;
    lcDiv <= (lcDiv == 29) ? 0 : lcDiv + 1;
    if (c4Div == 14)
    begin
      c4 <= ~c4;
      if (!c4) cnt <= cnt + 9'h001;
    end
    if (lcDiv == 29)
    begin
      lc <= ~lc;
      if (!lc) lcnt <= lcnt + 8'h01;
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic bw(input logic [4:0] a, input logic [7:0] d);
    cyc(1);
    busAddr = a;
    busDataIn = d;
    busCsN = 1'b0;
    busWrN = 1'b0;
    cyc(6);
    busCsN = 1'b1;
    busWrN = 1'b1;
    cyc(6);
  endtask

  task automatic br(input logic [4:0] a, input logic [7:0] exp, input logic oe);
    int n;
    n = 0;
    cyc(1);
    busAddr = a;
    busCsN = 1'b0;
    busRdN = 1'b0;
    while (busDataOe !== 1'b1 && n < 10)
    begin
      cyc(1);
      n++;
    end
    chk("read enable", busDataOe, oe);
    if (oe) chk("read data", busDataOut, exp);
    busCsN = 1'b1;
    busRdN = 1'b1;
    cyc(6);
  endtask

  task automatic ackIt;
    ack = ~ack;
    cyc(2);
    chk("vector cleared", irqVector, 8'h00);
    chk("irq released", irqN, 1'b1);
  endtask

  task automatic fire(input int i, input logic hold);
    ev[i] = 1'b1;
    cyc(1);
    if (!hold) ev[i] = 1'b0;
    cyc(2);
  endtask

  task automatic regsTest;
    logic [4:0] a;
    for (int k = 0; k < 5; k++)
    begin
      a = e1_irq_pkg::ADDR_SIG_CTL + 5'(k);
      br(a, (k == 1) ? 8'hFF : 8'h00, 1'b1);
      bw(a, 8'h5A ^ 8'(k));
      br(a, 8'h5A ^ 8'(k), 1'b1);
      bw(a, (k == 1) ? 8'hFF : 8'h00);
    end
    bw(5'h1F, 8'h33);
    br(5'h1F, 8'h00, 1'b0);
    br(5'h19, 8'h00, 1'b0);
  endtask

  task automatic evCase(input int i);
    logic [4:0] a;
    logic [7:0] m;
    a = e1_irq_pkg::ADDR_MASK0 + 5'(i / 8);
    m = 8'h01 << (i % 8);
    if (i < 8) m = ~m;
    fire(i, 1'b0);
    chk("masked event", irqVector, 8'h00);
    bw(a, m);
    fire(i, i == CHG);
    chk("event vector", irqVector, 8'h01 << GRP[i]);
    chk("irq low", irqN, 1'b0);
    ackIt;
    if (i == CHG)
    begin
      ev[i] = 1'b0;
      cyc(2);
      chk("align fall", irqVector, 8'h08);
      ackIt;
    end
    bw(a, (i < 8) ? 8'hFF : 8'h00);
  endtask

  task automatic cond(input logic a, input logic e, input int n);
    aOne = a;
    eZero = e;
    cyc(n);
    aOne = 1'b0;
    eZero = 1'b0;
    cyc(3);
  endtask

  task automatic rcrTest;
    bw(e1_irq_pkg::ADDR_MASK1, 8'h08);
    cond(1'b1, 1'b1, 5);
    chk("short alarm", irqVector, 8'h00);
    cond(1'b1, 1'b0, 20);
    chk("a bit only", irqVector, 8'h00);
    cond(1'b1, 1'b1, 20);
    chk("long alarm", irqVector, 8'h20);
    ackIt;
    bw(e1_irq_pkg::ADDR_MASK1, 8'h04);
    cond(1'b1, 1'b1, 60);
    chk("too long window", irqVector, 8'h00);
    cond(1'b1, 1'b1, 20);
    chk("window alarm", irqVector, 8'h20);
    ackIt;
    bw(e1_irq_pkg::ADDR_MASK1, 8'h00);
  endtask

  task automatic miscTest;
    bw(e1_irq_pkg::ADDR_MASK0, 8'hFE);
    susp = 1'b1;
    cyc(2);
    chk("irq floated", irqOe, 1'b0);
    fire(0, 1'b0);
    chk("ignored event", irqVector, 8'h00);
    susp = 1'b0;
    cyc(2);
    chk("irq driven", irqOe, 1'b1);
    fire(0, 1'b0);
    susp = 1'b1;
    cyc(2);
    chk("pending kept", irqVector, 8'h04);
    susp = 1'b0;
    ackIt;
    ackIt;
    bw(e1_irq_pkg::ADDR_MASK0, 8'hFF);
    for (int k = 0; k < 2; k++)
    begin
      hs[k] = 1'b1;
      he[k] = 1'b1;
      cyc(1);
      he[k] = 1'b0;
      cyc(2);
      chk("link event", irqVector, 8'h02);
      ackIt;
      hs[k] = 1'b0;
      he[k] = 1'b1;
      cyc(1);
      he[k] = 1'b0;
      cyc(2);
      chk("deselected link", irqVector, 8'h00);
    end
    bw(e1_irq_pkg::ADDR_SIG_CTL, 8'h04);
    chk("counter clear", clrOut, 1'b1);
    bw(e1_irq_pkg::ADDR_SIG_CTL, 8'h00);
    chk("counter run", clrOut, 1'b0);
  endtask

  task automatic ccsTest;
    int f, l, s, r;
    logic p;
    f = -1;
    l = 0;
    s = 0;
    r = 0;
    ccsIn = 1'b1;
    bw(e1_irq_pkg::ADDR_SIG_CTL, 8'h01);
    chk("rx clock enable", rxClkOe, 1'b1);
    while (cnt !== 9'h000) cyc(1);
    p = rxClk;
    for (int n = 0; n < 512 * 30; n++)
    begin
      if (txStb === 1'b1)
      begin
        s++;
        if (f < 0) f = n;
        l = n;
        chk("ccs bit in", txBit, 1'b1);
      end
      if (rxClk === 1'b1 && p !== 1'b1) r++;
      p = rxClk;
      cyc(1);
    end
    chk("tx clock rises", s, 8);
    chk("tx clock span", l - f, 7 * SLOT);
    chk("first rise", f >= 960 && f < 976, 1);
    chk("rx clock rises", r, 8);
    chk("ccs out", sigOut, 1'b1);
    chk("ccs out enable", sigOe, 1'b1);
    ccsIn = 1'b0;
    bw(e1_irq_pkg::ADDR_SIG_CTL, 8'h00);
    chk("rx clock off", {rxClkOe, rxClk}, 2'h0);
  endtask

  task automatic at(input logic [8:0] c);
    while (cnt !== c) cyc(1);
    cyc(10);
  endtask

  task automatic msnTest(input logic v);
    int n;
    n = 0;
    msnTb = v;
    bw(e1_irq_pkg::ADDR_SIG_CTL, {6'h00, v, 1'b0});
    at(v ? 9'h051 : 9'h059);
    chk("nibble a", {sigOe, sigOut}, {1'b1, rxNib[3]});
    at(v ? 9'h055 : 9'h05D);
    chk("nibble c", {sigOe, sigOut}, {1'b1, rxNib[1]});
    at(v ? 9'h059 : 9'h061);
    chk("other half", sigOe, 1'b0);
    while (abcdStb !== 1'b1 && n < 600)
    begin
      cyc(1);
      n++;
    end
    chk("nibble in", txNib, tbNib);
  endtask

  task print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // the whole run needs roughly 50k cycles
  initial
  begin
    #(90000 * 8);
    failures++;
    print_verdict;
  end

  initial
  begin
    cyc(16);
    rst = 1'b0;
    cyc(2);
    chk("reset irq", {irqOe, irqN, irqVector}, 10'h300);
    regsTest;
    for (int i = 0; i < 32; i++)
      if (GRP[i] >= 0) evCase(i);
    rcrTest;
    miscTest;
    ccsTest;
    msnTest(1'b1);
    msnTest(1'b0);
    print_verdict;
  end
endmodule // e1_irq_ccs_ctl_tb

// ### verilog/e1_irq_ccs_ctl.sv
`timescale 1ns/100ps
module e1_irq_ccs_ctl #(
  parameter logic [e1_irq_pkg::RAI_CNT_W-1:0] RAI_MIN_CYCLES = e1_irq_pkg::RAI_MIN_COUNT,
  parameter logic [e1_irq_pkg::RAI_CNT_W-1:0] RAI_MAX_CYCLES = e1_irq_pkg::RAI_MAX_COUNT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic busCsN,
  input wire logic busRdN,
  input wire logic busWrN,
  input wire logic [e1_irq_pkg::ADDR_W-1:0] busAddr,
  input wire logic [e1_irq_pkg::DATA_W-1:0] busDataIn,
  output logic [e1_irq_pkg::DATA_W-1:0] busDataOut,
  output logic busDataOe,
  input wire logic backplane4mhzClockIn,
  input wire logic backplaneFrameN,
  input wire logic signallingSerialIn,
  output logic signallingSerialOut,
  output logic signallingSerialOe,
  input wire logic lineClockIn,
  input wire logic lineFrameIn,
  output logic rxCcsClockOut,
  output logic rxCcsClockOe,
  input wire logic rxCcsBit,
  input wire logic [3:0] rxAbcdNibble,
  output logic txCcsBit,
  output logic txCcsStrobe,
  output logic [3:0] txAbcdNibble,
  output logic txAbcdStrobe,
  output logic statusCounterClear,
  input wire logic frameSyncLoss,
  input wire logic remoteAlarm,
  input wire logic allOnesAlarm,
  input wire logic ts16AllOnes,
  input wire logic signalLoss,
  input wire logic frameErrorEvt,
  input wire logic bpvCounterWrap,
  input wire logic slipEvt,
  input wire logic remoteCrcErrorEvt,
  input wire logic localCrcErrorEvt,
  input wire logic doubleFasErrorEvt,
  input wire logic bipolarViolationEvt,
  input wire logic rxAbitOne,
  input wire logic rxEbitsZero,
  input wire logic testBitErrorEvt,
  input wire logic abcdChangeEvt,
  input wire logic ebitCounterWrap,
  input wire logic crcCounterWrap,
  input wire logic crcAlignStatus,
  input wire logic fasCounterWrap,
  input wire logic jitterFifoNearLimit,
  input wire logic testErrorCounterWrap,
  input wire logic auxPatternStatus,
  input wire logic crcMultiframeWrap,
  input wire logic sigMultiframeLoss,
  input wire logic crcMultiframeLoss,
  input wire logic remoteMultiframeAlarm,
  input wire logic oneSecondStatus,
  input wire logic firstTimerStatus,
  input wire logic secondTimerStatus,
  input wire logic hdlc0Select,
  input wire logic hdlc1Select,
  input wire logic hdlc0Evt,
  input wire logic hdlc1Evt,
  input wire logic irqAckToggle,
  input wire logic irqSuspend,
  output logic irqN,
  output logic irqOe,
  output logic [7:0] irqVector
);

  localparam int LVL_W = 14;

  typedef struct packed {
    e1_irq_pkg::pins_s meta;
    e1_irq_pkg::pins_s sync;
    logic c4Prev;
    logic lineClkPrev;
    logic [7:0] ctl;
    logic [7:0] mask0;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] mask3;
    logic [LVL_W-1:0] lvlPrev;
    logic ackPrev;
    logic [e1_irq_pkg::RAI_CNT_W-1:0] raiCnt;
    logic [e1_irq_pkg::C4_CNT_W-1:0] c4Cnt;
    logic [e1_irq_pkg::LINE_CNT_W-1:0] lineCnt;
    logic txCcsClk;
    logic rxCcsClk;
    logic rxCcsOe;
    logic sigOut;
    logic sigOe;
    logic txBit;
    logic txBitStrobe;
    logic [3:0] txShift;
    logic [3:0] txNibble;
    logic txNibbleStrobe;
    logic [7:0] dataOut;
    logic dataOe;
    logic irqN;
    logic irqOe;
    logic [7:0] vector;
    logic counter_clear_ctl;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  e1_irq_pkg::pins_s pinsNow;
  logic [LVL_W-1:0] lvlNow;
  logic [LVL_W-1:0] lvlRise;
  logic crcAlignChange;
  logic raiCond;
  logic raiLongEvt;
  logic raiWindowEvt;
  logic [e1_irq_pkg::EVT_COUNT-1:0] rawEvt;
  logic [e1_irq_pkg::EVT_COUNT-1:0] unmasked;
  logic hdlcEvt;
  logic [7:0] newSet;
  logic ackToggle;
  logic c4Rise;
  logic lineRise;
  logic validHalf;

  function automatic logic addrHit(input logic [e1_irq_pkg::ADDR_W-1:0] a);
    addrHit = (a >= e1_irq_pkg::ADDR_SIG_CTL) && (a <= e1_irq_pkg::ADDR_MASK3);
  endfunction

  assign pinsNow = '{csN: busCsN, rdN: busRdN, wrN: busWrN, addr: busAddr, data: busDataIn,
                     c4: backplane4mhzClockIn, frameN: backplaneFrameN,
                     sigIn: signallingSerialIn, lineClk: lineClockIn, lineFrame: lineFrameIn};

  always_comb
  begin
    st_nxt = st_r;
    // pins pass two flops; only the second stage is looked at
    st_nxt.meta = pinsNow;
    st_nxt.sync = st_r.meta;

    // writes follow the data for as long as the strobe is held, so the
    // value present when the strobe ends is what stays
    if (!st_r.sync.csN && !st_r.sync.wrN && addrHit(st_r.sync.addr))
    begin
      case (st_r.sync.addr)
        e1_irq_pkg::ADDR_SIG_CTL: st_nxt.ctl = st_r.sync.data;
        e1_irq_pkg::ADDR_MASK0: st_nxt.mask0 = st_r.sync.data;
        e1_irq_pkg::ADDR_MASK1: st_nxt.mask1 = st_r.sync.data;
        e1_irq_pkg::ADDR_MASK2: st_nxt.mask2 = st_r.sync.data;
        e1_irq_pkg::ADDR_MASK3: st_nxt.mask3 = st_r.sync.data;
        default: st_nxt.ctl = st_r.ctl;
      endcase
    end
    st_nxt.dataOe = !st_r.sync.csN && !st_r.sync.rdN && addrHit(st_r.sync.addr);
    case (st_r.sync.addr)
      e1_irq_pkg::ADDR_SIG_CTL: st_nxt.dataOut = st_r.ctl;
      e1_irq_pkg::ADDR_MASK0: st_nxt.dataOut = st_r.mask0;
      e1_irq_pkg::ADDR_MASK1: st_nxt.dataOut = st_r.mask1;
      e1_irq_pkg::ADDR_MASK2: st_nxt.dataOut = st_r.mask2;
      e1_irq_pkg::ADDR_MASK3: st_nxt.dataOut = st_r.mask3;
      default: st_nxt.dataOut = '0;
    endcase

    // only clears the counters; masks never touch them
    st_nxt.counter_clear_ctl = st_nxt.ctl[e1_irq_pkg::CTL_COUNTER_CLEAR_CTL]; // RULE1 RULE27

    // backplane timing, counted in 4 MHz periods from the frame pulse
    c4Rise = st_r.sync.c4 && !st_r.c4Prev;
    st_nxt.c4Prev = st_r.sync.c4;
    st_nxt.txBitStrobe = 1'b0;
    st_nxt.txNibbleStrobe = 1'b0;
    if (c4Rise)
    begin
      if (!st_r.sync.frameN)
      begin
        st_nxt.c4Cnt = '0;
      end
      else
      begin
        st_nxt.c4Cnt = st_r.c4Cnt + 1'b1;
      end
    end
    st_nxt.txCcsClk = st_nxt.c4Cnt[e1_irq_pkg::CCS_TX_BIT]; // RULE4
    // judged against the control value that stands beside the registered drive
    validHalf = st_nxt.c4Cnt[e1_irq_pkg::HALF_BIT] == !st_nxt.ctl[e1_irq_pkg::CTL_MSN]; // RULE2

    if (st_r.ctl[e1_irq_pkg::CTL_CCS])
    begin
      if (st_nxt.txCcsClk && !st_r.txCcsClk)
      begin
        st_nxt.txBit = st_r.sync.sigIn; // RULE3
        st_nxt.txBitStrobe = 1'b1;
      end
    end
    else if (c4Rise && st_nxt.c4Cnt[0] && validHalf)
    begin
      // sample mid-bit, nibble is complete on its fourth bit
      st_nxt.txShift = {st_r.txShift[2:0], st_r.sync.sigIn}; // RULE2
      if (st_nxt.c4Cnt[2:1] == e1_irq_pkg::NIBBLE_LAST)
      begin
        st_nxt.txNibble = st_nxt.txShift;
        st_nxt.txNibbleStrobe = 1'b1;
      end
    end

    // receive side timing from the extracted line clock
    lineRise = st_r.sync.lineClk && !st_r.lineClkPrev;
    st_nxt.lineClkPrev = st_r.sync.lineClk;
    if (lineRise)
    begin
      if (st_r.sync.lineFrame)
      begin
        st_nxt.lineCnt = '0;
      end
      else
      begin
        st_nxt.lineCnt = st_r.lineCnt + 1'b1;
      end
    end
    st_nxt.rxCcsOe = st_r.ctl[e1_irq_pkg::CTL_CCS]; // RULE5
    st_nxt.rxCcsClk = st_r.ctl[e1_irq_pkg::CTL_CCS] &&
                      st_nxt.lineCnt[e1_irq_pkg::CCS_RX_BIT]; // RULE5

    if (st_nxt.ctl[e1_irq_pkg::CTL_CCS])
    begin
      // change on the falling edge so the far end samples a settled bit
      st_nxt.sigOe = 1'b1;
      if (!st_nxt.rxCcsClk && st_r.rxCcsClk)
      begin
        st_nxt.sigOut = rxCcsBit; // RULE3
      end
    end
    else
    begin
      st_nxt.sigOe = validHalf; // RULE2
      st_nxt.sigOut = rxAbcdNibble[~st_nxt.c4Cnt[2:1]];
    end

    // events
    lvlNow = {frameSyncLoss, remoteAlarm, allOnesAlarm, ts16AllOnes, signalLoss,
              jitterFifoNearLimit, auxPatternStatus, sigMultiframeLoss, crcMultiframeLoss,
              remoteMultiframeAlarm, oneSecondStatus, firstTimerStatus, secondTimerStatus,
              crcAlignStatus};
    lvlRise = lvlNow & ~st_r.lvlPrev;
    crcAlignChange = lvlNow[0] ^ st_r.lvlPrev[0]; // RULE17
    st_nxt.lvlPrev = lvlNow;

    // the window event fires when the condition ends, the only point where
    // its length is known to be under the upper limit
    raiCond = rxAbitOne && rxEbitsZero;
    raiLongEvt = raiCond && (st_r.raiCnt == RAI_MIN_CYCLES); // RULE13
    raiWindowEvt = !raiCond && (st_r.raiCnt > RAI_MIN_CYCLES) &&
                   (st_r.raiCnt < RAI_MAX_CYCLES); // RULE14
    if (!raiCond)
    begin
      st_nxt.raiCnt = '0;
    end
    else if (st_r.raiCnt < RAI_MAX_CYCLES)
    begin
      st_nxt.raiCnt = st_r.raiCnt + 1'b1;
    end

    rawEvt = {lvlRise[13:9], frameErrorEvt, bpvCounterWrap, slipEvt, // RULE6 RULE7 RULE8 RULE9 RULE10
              remoteCrcErrorEvt, localCrcErrorEvt, doubleFasErrorEvt, bipolarViolationEvt, // RULE11 RULE12
              raiLongEvt, raiWindowEvt, testBitErrorEvt, abcdChangeEvt, // RULE15
              ebitCounterWrap, crcCounterWrap, crcAlignChange, fasCounterWrap, // RULE16
              lvlRise[8], testErrorCounterWrap, lvlRise[7], crcMultiframeWrap, // RULE18 RULE19
              lvlRise[6:5], 1'b0, lvlRise[4:1], 1'b0}; // RULE20 RULE21 RULE22
    unmasked = rawEvt & {~st_r.mask0, st_r.mask1, st_r.mask2, st_r.mask3}; // RULE6 RULE11
    newSet = '0;
    for (int i = 0; i < e1_irq_pkg::EVT_COUNT; i++)
    begin
      if (unmasked[i])
      begin
        newSet[e1_irq_pkg::EVT_GROUP[i]] = 1'b1;
      end
    end
    hdlcEvt = (hdlc0Evt && hdlc0Select) || (hdlc1Evt && hdlc1Select); // RULE25
    newSet[e1_irq_pkg::GRP_LINK] = newSet[e1_irq_pkg::GRP_LINK] || hdlcEvt;
    if (irqSuspend)
    begin
      newSet = '0; // RULE24
    end

    // an event in the acknowledge cycle survives the clear
    ackToggle = irqAckToggle ^ st_r.ackPrev;
    st_nxt.ackPrev = irqAckToggle;
    st_nxt.vector = (ackToggle ? 8'h00 : st_r.vector) | newSet; // RULE23 RULE26
    st_nxt.irqN = ~|st_nxt.vector; // RULE26
    st_nxt.irqOe = !irqSuspend; // RULE24
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.meta <= e1_irq_pkg::PINS_IDLE;
      st_r.sync <= e1_irq_pkg::PINS_IDLE;
      st_r.ctl <= e1_irq_pkg::CTL_RESET;
      st_r.mask0 <= e1_irq_pkg::MASK0_RESET;
      st_r.mask1 <= e1_irq_pkg::MASKN_RESET;
      st_r.mask2 <= e1_irq_pkg::MASKN_RESET;
      st_r.mask3 <= e1_irq_pkg::MASKN_RESET;
      st_r.irqN <= 1'b1;
      st_r.irqOe <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign busDataOut = st_r.dataOut;
  assign busDataOe = st_r.dataOe;
  assign signallingSerialOut = st_r.sigOut;
  assign signallingSerialOe = st_r.sigOe;
  assign rxCcsClockOut = st_r.rxCcsClk;
  assign rxCcsClockOe = st_r.rxCcsOe;
  assign txCcsBit = st_r.txBit;
  assign txCcsStrobe = st_r.txBitStrobe;
  assign txAbcdNibble = st_r.txNibble;
  assign txAbcdStrobe = st_r.txNibbleStrobe;
  assign statusCounterClear = st_r.counter_clear_ctl;
  assign irqN = st_r.irqN;
  assign irqOe = st_r.irqOe;
  assign irqVector = st_r.vector;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  counter_clear_a: assert property (st_r.ctl[e1_irq_pkg::CTL_COUNTER_CLEAR_CTL] |-> statusCounterClear) // RULE1
    else $error("counter clear not held while control bit set");
  nibble_half_a: assert property (!st_r.ctl[e1_irq_pkg::CTL_CCS] && st_r.sigOe |->
    st_r.c4Cnt[e1_irq_pkg::HALF_BIT] != st_r.ctl[e1_irq_pkg::CTL_MSN]) // RULE2
    else $error("signalling nibble driven in wrong half of slot");
  ccs_tx_edge_a: assert property ($rose(st_r.txCcsClk) |->
    st_r.c4Cnt[e1_irq_pkg::SLOT_LSB+1:e1_irq_pkg::SLOT_LSB] == e1_irq_pkg::CCS_RISE_CHAN &&
    st_r.c4Cnt[e1_irq_pkg::SLOT_LSB-1:0] == '0) // RULE4
    else $error("transmit ccs clock rose off a channel boundary");
  ccs_rx_drive_a: assert property (!st_r.ctl[e1_irq_pkg::CTL_CCS] |=>
    !rxCcsClockOe && !rxCcsClockOut) // RULE5
    else $error("receive ccs clock driven while not selected");
  sync_loss_a: assert property ($rose(frameSyncLoss) && !st_r.mask0[7] && !irqSuspend |=>
    irqVector[e1_irq_pkg::GRP_SYNC] && !irqN) // RULE6
    else $error("frame sync loss did not raise interrupt");
  slip_irq_a: assert property (slipEvt && st_r.mask0[0] && irqVector == 8'h00 &&
    rawEvt == 32'h0100_0000 && !hdlcEvt |=> irqN) // RULE10
    else $error("masked slip raised interrupt");
  rai_long_a: assert property (raiLongEvt && st_r.mask1[3] && !irqSuspend |=>
    irqVector[e1_irq_pkg::GRP_ERROR]) // RULE13
    else $error("long alarm condition not reported");
  ack_clear_a: assert property (ackToggle && newSet == 8'h00 |=> irqN && irqVector == 8'h00) // RULE23
    else $error("acknowledge toggle did not clear pending interrupts");
  ack_hold_a: assert property (!irqN && !ackToggle ##1 !ackToggle |-> !irqN) // RULE26
    else $error("pending interrupt dropped without acknowledge");
  suspend_float_a: assert property (irqSuspend [*2] |-> !irqOe && $stable(irqVector)) // RULE24
    else $error("interrupt output not floated or sources taken while suspended");
  hdlc_mask_a: assert property (!hdlc0Select && !hdlc1Select && irqVector == 8'h00 &&
    unmasked == '0 && !ackToggle |=> irqVector == 8'h00) // RULE25
    else $error("deselected link controller raised interrupt");

endmodule // e1_irq_ccs_ctl

// ### verilog/e1_irq_pkg.sv
// What this block does
// RULE1 - counter clear bit at one clears all status counters and holds them at zero
// RULE2 - nibble position bit picks upper or lower half of each slot for signalling nibbles
// RULE3 - common channel select takes bits from signalling input, shifts received ones out
// RULE4 - transmit common channel clock is 4 MHz divided to 64 kHz, channel aligned
// RULE5 - receive common channel clock follows line clock, driven out while select is set
// RULE6 - mask word zero unmasks with zero; frame sync loss sets vector bit 7
// RULE7 - remote alarm, all ones, slot 16 all ones, signal loss set vector bit 6
// RULE8 - frame alignment signal error sets vector bit 5 when unmasked by zero
// RULE9 - bipolar violation counter wrap sets vector bit 4 when unmasked by zero
// RULE10 - controlled frame slip sets vector bit 2 when unmasked by zero
// RULE11 - words one to three unmask with one; remote, local CRC, violation, test errors bit 5
// RULE12 - two consecutive errored alignment signals set vector bit 5
// RULE13 - A one and E zero held over 10 ms fires first alarm interrupt
// RULE14 - that condition lasting over 10 ms but under 450 ms fires second interrupt
// RULE15 - any received ABCD bit change sets vector bit 0
// RULE16 - E-bit, CRC, alignment error, bit error, multiframe counter overflow set bit 4
// RULE17 - any change of CRC alignment status sets vector bit 3
// RULE18 - jitter FIFO within four bytes of over or underflow sets vector bit 2
// RULE19 - auxiliary pattern status going high sets vector bit 6
// RULE20 - signalling or CRC multiframe sync loss sets vector bit 7
// RULE21 - remote signalling multiframe alarm sets vector bit 7
// RULE22 - one second, first and second timer rising edges set vector bit 3
// RULE23 - any toggle of acknowledge bit clears pending interrupts, output returns high
// RULE24 - suspend bit floats the interrupt output and ignores all sources
// RULE25 - a deselected link controller has all its interrupts masked
// RULE26 - unmasked events latch into the vector and hold the output low until acknowledged
// RULE27 - masks gate only interrupts; status and counters keep running
package e1_irq_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_SIG_CTL = 5'h1A;
  localparam logic [ADDR_W-1:0] ADDR_MASK0 = 5'h1B;
  localparam logic [ADDR_W-1:0] ADDR_MASK1 = 5'h1C;
  localparam logic [ADDR_W-1:0] ADDR_MASK2 = 5'h1D;
  localparam logic [ADDR_W-1:0] ADDR_MASK3 = 5'h1E;
  localparam int CTL_COUNTER_CLEAR_CTL = 2;
  localparam int CTL_MSN = 1;
  localparam int CTL_CCS = 0;
  localparam logic [DATA_W-1:0] CTL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] MASK0_RESET = 8'hFF;
  localparam logic [DATA_W-1:0] MASKN_RESET = 8'h00;
  localparam int GRP_SIG = 0;
  localparam int GRP_LINK = 1;
  localparam int GRP_SLIP = 2;
  localparam int GRP_STATUS = 3;
  localparam int GRP_WRAP = 4;
  localparam int GRP_ERROR = 5;
  localparam int GRP_ALARM = 6;
  localparam int GRP_SYNC = 7;
  localparam int EVT_COUNT = 32;
  // index 0 is mask word three bit 0, index 31 is mask word zero bit 7
  localparam int EVT_GROUP [EVT_COUNT] = '{
    GRP_SIG, GRP_STATUS, GRP_STATUS, GRP_STATUS, GRP_SYNC, GRP_SIG, GRP_SYNC, GRP_SYNC,
    GRP_WRAP, GRP_ALARM, GRP_WRAP, GRP_SLIP, GRP_WRAP, GRP_STATUS, GRP_WRAP, GRP_WRAP,
    GRP_SIG, GRP_ERROR, GRP_ERROR, GRP_ERROR, GRP_ERROR, GRP_ERROR, GRP_ERROR, GRP_ERROR,
    GRP_SLIP, GRP_WRAP, GRP_ERROR, GRP_ALARM, GRP_ALARM, GRP_ALARM, GRP_ALARM, GRP_SYNC};
  localparam int CLK_KHZ = 125000;
  localparam int RAI_MIN_MS = 10;
  localparam int RAI_MAX_MS = 450;
  localparam int RAI_CNT_W = 27;
  localparam logic [RAI_CNT_W-1:0] RAI_MIN_COUNT = RAI_CNT_W'(RAI_MIN_MS * CLK_KHZ);
  localparam logic [RAI_CNT_W-1:0] RAI_MAX_COUNT = RAI_CNT_W'(RAI_MAX_MS * CLK_KHZ);
  localparam int C4_CNT_W = 9;
  localparam int LINE_CNT_W = 8;
  localparam int CCS_TX_BIT = 5;
  localparam int CCS_RX_BIT = 4;
  localparam int SLOT_LSB = 4;
  localparam int HALF_BIT = 3;
  localparam logic [1:0] CCS_RISE_CHAN = 2'h2;
  localparam logic [1:0] NIBBLE_LAST = 2'h3;
  typedef struct packed {
    logic csN;
    logic rdN;
    logic wrN;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic c4;
    logic frameN;
    logic sigIn;
    logic lineClk;
    logic lineFrame;
  } pins_s;
  localparam pins_s PINS_IDLE = '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, frameN: 1'b1, default: '0};
endpackage
